/* verilog/bsts_map.svh */
`ifndef BSTS_MAP_SVH
`define BSTS_MAP_SVH

`define BSTS_IR_W 3
`define BSTS_ID_W 32
`define BSTS_BND_LEN 166
`define BSTS_DTA_CELL 147

`define BSTS_OP_EXTEST 3'h0
`define BSTS_OP_IDCODE 3'h1
`define BSTS_OP_SAMPLE 3'h2
`define BSTS_OP_BYPASS 3'h7
`define BSTS_IR_CAPTURE 3'h1

`define BSTS_TCK_PERIOD_NS 80
`define BSTS_CLK_PERIOD_NS 5
`define BSTS_TCK_CYCLES (`BSTS_TCK_PERIOD_NS / `BSTS_CLK_PERIOD_NS)

`endif

/* verilog/bsts_pkg.sv */
package bsts_pkg;

    typedef enum logic [3:0] {
        BSTS_TLR = 4'h0,
        BSTS_RTI = 4'h1,
        BSTS_SEL_DR = 4'h2,
        BSTS_CAP_DR = 4'h3,
        BSTS_SHIFT_DR = 4'h4,
        BSTS_EXIT1_DR = 4'h5,
        BSTS_PAUSE_DR = 4'h6,
        BSTS_EXIT2_DR = 4'h7,
        BSTS_UPD_DR = 4'h8,
        BSTS_SEL_IR = 4'h9,
        BSTS_CAP_IR = 4'hA,
        BSTS_SHIFT_IR = 4'hB,
        BSTS_EXIT1_IR = 4'hC,
        BSTS_PAUSE_IR = 4'hD,
        BSTS_EXIT2_IR = 4'hE,
        BSTS_UPD_IR = 4'hF
    } bsts_state_e;

    typedef logic [2:0] bsts_instr_t;

endpackage : bsts_pkg

/* verilog/bsts_chain.sv */
`timescale 1ns/1ps
`include "bsts_map.svh"

module bsts_chain (
    input wire logic clk,
    input wire logic reset,
    input wire logic scan_reset,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic scan_in,
    input wire logic [`BSTS_BND_LEN-1:0] pins_in,
    output logic scan_out,
    output logic [`BSTS_BND_LEN-1:0] cells_out
);

    logic [`BSTS_BND_LEN-1:0] shift_r;
    logic [`BSTS_BND_LEN:0] chain_in;

    // scan_in sits above the top cell, so every cell simply takes its upper neighbour
    assign chain_in = {scan_in, shift_r};

    // cell 0 sits next to the output, so it leaves first
    genvar i;
    generate
        for (i = 0; i < `BSTS_BND_LEN; i = i + 1) begin : g_cell
            always_ff @(posedge clk) begin
                if (reset || scan_reset) begin
                    shift_r[i] <= 1'b0;
                end else if (capture) begin
                    shift_r[i] <= pins_in[i];
                end else if (shift) begin
                    shift_r[i] <= chain_in[i+1];
                end
            end

            // held cells clear to zero, which is the safe released value for every pin
            always_ff @(posedge clk) begin
                if (reset || scan_reset) begin
                    cells_out[i] <= 1'b0;
                end else if (update) begin
                    cells_out[i] <= shift_r[i];
                end
            end
        end
    endgenerate

    assign scan_out = shift_r[0];

endmodule : bsts_chain

/* verilog/bsts_tap.sv */
`timescale 1ns/1ps
`include "bsts_map.svh"

module bsts_tap
    import bsts_pkg::*;
#(
    // arbitrary identification value, lsb fixed at one
    parameter logic [`BSTS_ID_W-1:0] ID_VALUE = 32'h0000_0001
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tms_driven,
    input wire logic tdi_pin,
    input wire logic tdi_driven,
    input wire logic trst_n_pin,
    input wire logic trst_n_driven,
    input wire logic [`BSTS_BND_LEN-1:0] bnd_pins_in,
    output logic tdo_pin,
    output logic tdo_oe,
    output logic extest_active,
    output logic [`BSTS_BND_LEN-1:0] bnd_cells_out,
    output logic transfer_ack_pin_out,
    output logic transfer_ack_pin_oe,
    output bsts_state_e tap_state
);

    logic tck_s1_r, tck_s2_r, tck_s3_r;
    logic tms_s1_r, tms_s2_r;
    logic [5:0] raw_s1_r, raw_s2_r;
    logic [`BSTS_BND_LEN-1:0] bnd_s1_r, bnd_s2_r;
    logic tdi_s1_r, tdi_s2_r;
    logic trst_n_s1_r, trst_n_s2_r;
    logic tck_rise, tck_fall, scan_reset;
    bsts_state_e state_r, state_nxt;
    bsts_instr_t ir_shift_r, ir_r;
    logic bypass_r;
    logic [`BSTS_ID_W-1:0] id_shift_r;
    logic sel_id, sel_bnd;
    logic bnd_capture, bnd_shift, bnd_update, bnd_so;

    // pins and their drive flags pass two flops before any choice is made on them
    always_ff @(posedge clk) begin
        if (reset) begin
            raw_s1_r <= 6'h3F;
            raw_s2_r <= 6'h3F;
        end else begin
            raw_s1_r <= {tms_pin, tms_driven, tdi_pin, tdi_driven, trst_n_pin, trst_n_driven};
            raw_s2_r <= raw_s1_r;
        end
    end

    // captured pin values are synchronised too; capture comes long after they settle
    always_ff @(posedge clk) begin
        if (reset) begin
            bnd_s1_r <= '0;
            bnd_s2_r <= '0;
        end else begin
            bnd_s1_r <= bnd_pins_in;
            bnd_s2_r <= bnd_s1_r;
        end
    end

    // the pull-up wins whenever the tester lets go of a pin
    always_ff @(posedge clk) begin
        if (reset) begin
            tms_s1_r <= 1'b1;
            tms_s2_r <= 1'b1;
            tdi_s1_r <= 1'b1;
            tdi_s2_r <= 1'b1;
            trst_n_s1_r <= 1'b1;
            trst_n_s2_r <= 1'b1;
        end else begin
            tms_s1_r <= raw_s2_r[4] ? raw_s2_r[5] : 1'b1;
            tms_s2_r <= tms_s1_r;
            tdi_s1_r <= raw_s2_r[2] ? raw_s2_r[3] : 1'b1;
            tdi_s2_r <= tdi_s1_r;
            trst_n_s1_r <= raw_s2_r[0] ? raw_s2_r[1] : 1'b1;
            trst_n_s2_r <= trst_n_s1_r;
        end
    end

    // test clock is only sampled; the core clock never depends on it
    always_ff @(posedge clk) begin
        if (reset) begin
            tck_s1_r <= 1'b0;
            tck_s2_r <= 1'b0;
            tck_s3_r <= 1'b0;
        end else begin
            tck_s1_r <= tck_pin;
            tck_s2_r <= tck_s1_r;
            tck_s3_r <= tck_s2_r;
        end
    end

    assign tck_rise = tck_s2_r & ~tck_s3_r;
    assign tck_fall = ~tck_s2_r & tck_s3_r;
    assign scan_reset = ~trst_n_s2_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BSTS_TLR: state_nxt = tms_s2_r ? BSTS_TLR : BSTS_RTI;
            BSTS_RTI: state_nxt = tms_s2_r ? BSTS_SEL_DR : BSTS_RTI;
            BSTS_SEL_DR: state_nxt = tms_s2_r ? BSTS_SEL_IR : BSTS_CAP_DR;
            BSTS_CAP_DR: state_nxt = tms_s2_r ? BSTS_EXIT1_DR : BSTS_SHIFT_DR;
            BSTS_SHIFT_DR: state_nxt = tms_s2_r ? BSTS_EXIT1_DR : BSTS_SHIFT_DR;
            BSTS_EXIT1_DR: state_nxt = tms_s2_r ? BSTS_UPD_DR : BSTS_PAUSE_DR;
            BSTS_PAUSE_DR: state_nxt = tms_s2_r ? BSTS_EXIT2_DR : BSTS_PAUSE_DR;
            BSTS_EXIT2_DR: state_nxt = tms_s2_r ? BSTS_UPD_DR : BSTS_SHIFT_DR;
            BSTS_UPD_DR: state_nxt = tms_s2_r ? BSTS_SEL_DR : BSTS_RTI;
            BSTS_SEL_IR: state_nxt = tms_s2_r ? BSTS_TLR : BSTS_CAP_IR;
            BSTS_CAP_IR: state_nxt = tms_s2_r ? BSTS_EXIT1_IR : BSTS_SHIFT_IR;
            BSTS_SHIFT_IR: state_nxt = tms_s2_r ? BSTS_EXIT1_IR : BSTS_SHIFT_IR;
            BSTS_EXIT1_IR: state_nxt = tms_s2_r ? BSTS_UPD_IR : BSTS_PAUSE_IR;
            BSTS_PAUSE_IR: state_nxt = tms_s2_r ? BSTS_EXIT2_IR : BSTS_PAUSE_IR;
            BSTS_EXIT2_IR: state_nxt = tms_s2_r ? BSTS_UPD_IR : BSTS_SHIFT_IR;
            BSTS_UPD_IR: state_nxt = tms_s2_r ? BSTS_SEL_DR : BSTS_RTI;
            default: state_nxt = BSTS_TLR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset || scan_reset) begin
            state_r <= BSTS_TLR;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || scan_reset) begin
            ir_shift_r <= `BSTS_OP_BYPASS;
        end else if (tck_rise && state_r == BSTS_CAP_IR) begin
            ir_shift_r <= `BSTS_IR_CAPTURE;
        end else if (tck_rise && state_r == BSTS_SHIFT_IR) begin
            ir_shift_r <= {tdi_s2_r, ir_shift_r[`BSTS_IR_W-1:1]};
        end
    end

    always_ff @(posedge clk) begin
        if (reset || scan_reset || state_r == BSTS_TLR) begin
            ir_r <= `BSTS_OP_BYPASS;
        end else if (tck_fall && state_r == BSTS_UPD_IR) begin
            ir_r <= ir_shift_r;
        end
    end

    // anything not decoded falls through to bypass
    assign sel_id = (ir_r == `BSTS_OP_IDCODE);
    assign sel_bnd = (ir_r == `BSTS_OP_EXTEST) || (ir_r == `BSTS_OP_SAMPLE);

    always_ff @(posedge clk) begin
        if (reset || scan_reset) begin
            bypass_r <= 1'b0;
        end else if (tck_rise && state_r == BSTS_CAP_DR) begin
            bypass_r <= 1'b0;
        end else if (tck_rise && state_r == BSTS_SHIFT_DR) begin
            bypass_r <= tdi_s2_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || scan_reset) begin
            id_shift_r <= ID_VALUE;
        end else if (tck_rise && state_r == BSTS_CAP_DR) begin
            id_shift_r <= ID_VALUE;
        end else if (tck_rise && state_r == BSTS_SHIFT_DR && sel_id) begin
            id_shift_r <= {tdi_s2_r, id_shift_r[`BSTS_ID_W-1:1]};
        end
    end

    assign bnd_capture = tck_rise && state_r == BSTS_CAP_DR && sel_bnd;
    assign bnd_shift = tck_rise && state_r == BSTS_SHIFT_DR && sel_bnd;
    assign bnd_update = tck_fall && state_r == BSTS_UPD_DR && sel_bnd;

    // 166 cells, numbered 0 to 165
    bsts_chain u_chain (
        .clk(clk),
        .reset(reset),
        .scan_reset(scan_reset),
        .capture(bnd_capture),
        .shift(bnd_shift),
        .update(bnd_update),
        .scan_in(tdi_s2_r),
        .pins_in(bnd_s2_r),
        .scan_out(bnd_so),
        .cells_out(bnd_cells_out)
    );

    always_ff @(posedge clk) begin
        if (reset || scan_reset) begin
            tdo_pin <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (state_r == BSTS_SHIFT_IR) || (state_r == BSTS_SHIFT_DR);
            if (state_r == BSTS_SHIFT_IR) begin
                tdo_pin <= ir_shift_r[0];
            end else if (sel_bnd) begin
                tdo_pin <= bnd_so;
            end else if (sel_id) begin
                tdo_pin <= id_shift_r[0];
            end else begin
                tdo_pin <= bypass_r;
            end
        end
    end

    // pins are only taken over under extest, so sampling never touches the core
    always_ff @(posedge clk) begin
        if (reset || scan_reset) begin
            extest_active <= 1'b0;
            transfer_ack_pin_oe <= 1'b0;
        end else begin
            extest_active <= (ir_r == `BSTS_OP_EXTEST);
            transfer_ack_pin_oe <= (ir_r == `BSTS_OP_EXTEST) &&
                bnd_cells_out[`BSTS_DTA_CELL];
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge clk) begin
        transfer_ack_pin_out <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (reset || scan_reset) begin
            tap_state <= BSTS_TLR;
        end else begin
            tap_state <= state_nxt_seen();
        end
    end

    function automatic bsts_state_e state_nxt_seen();
        return tck_rise ? state_nxt : state_r;
    endfunction : state_nxt_seen

endmodule : bsts_tap

/* tb/bsts_tap_props.sv */
`timescale 1ns/1ps
`include "bsts_map.svh"
module bsts_tap_props
    import bsts_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tms_driven,
    input wire logic tdi_pin,
    input wire logic tdi_driven,
    input wire logic trst_n_pin,
    input wire logic trst_n_driven,
    input wire logic [`BSTS_BND_LEN-1:0] bnd_pins_in,
    input wire logic tdo_pin,
    input wire logic tdo_oe,
    input wire logic extest_active,
    input wire logic [`BSTS_BND_LEN-1:0] bnd_cells_out,
    input wire logic transfer_ack_pin_out,
    input wire logic transfer_ack_pin_oe,
    input wire bsts_state_e tap_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_clears: assert property (disable iff (1'b0) reset |=> tap_state == BSTS_TLR
        && !tdo_oe && !extest_active) else $error("reset left scan state");
    // state may only move while tck_pin is high and was high two cycles before, apart from moves into test-logic-reset
    a_state_on_rise: assert property ($changed(tap_state) && tap_state != BSTS_TLR
        |-> tck_pin && $past(tck_pin, 2)) else $error("state moved off tck rise");
    a_tdo_on_fall: assert property (($changed(tdo_pin) || $rose(tdo_oe))
        |-> !tck_pin && !$past(tck_pin, 2)) else $error("tdo moved off tck fall");
    a_tdo_released: assert property (tdo_oe |-> tap_state inside {BSTS_SHIFT_DR,
        BSTS_SHIFT_IR, BSTS_EXIT1_DR, BSTS_EXIT1_IR}) else $error("tdo driven outside shift");
    a_ack_never_high: assert property (!transfer_ack_pin_out)
        else $error("ack pin driven high");
    a_ack_follows_cell: assert property (transfer_ack_pin_oe |-> extest_active
        && (bnd_cells_out[`BSTS_DTA_CELL] || $past(bnd_cells_out[`BSTS_DTA_CELL])))
        else $error("ack pulled without cell");
    // test reset clears the latches in the same cycle that the shown state goes to test-logic-reset
    a_cells_on_fall: assert property ($changed(bnd_cells_out)
        && (trst_n_pin || !trst_n_driven) |-> !tck_pin && tap_state == BSTS_UPD_DR)
        else $error("cells updated out of turn");
    a_extest_on_update: assert property ($rose(extest_active)
        |-> !tck_pin && tap_state == BSTS_UPD_IR) else $error("instruction changed out of turn");
    c_tdo_on: cover property ($rose(tdo_oe));
    c_extest: cover property ($rose(extest_active));
    c_ack: cover property ($rose(transfer_ack_pin_oe));
endmodule : bsts_tap_props

/* tb/bsts_tester.sv */
`timescale 1ns/1ps
`include "bsts_map.svh"
module bsts_tester (
    input wire logic clk,
    input wire logic tdo_pin,
    input wire logic tdo_oe,
    output logic tck_pin,
    output logic tms_pin,
    output logic tms_driven,
    output logic tdi_pin,
    output logic tdi_driven,
    output logic trst_n_pin,
    output logic trst_n_driven
);
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        tms_driven = 1'b1;
        tdi_pin = 1'b1;
        tdi_driven = 1'b1;
        trst_n_pin = 1'b0;
        trst_n_driven = 1'b1;
    end
    // tck rests low between steps; a released tdo reads as unknown
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms_pin <= m;
        tdi_pin <= d;
        repeat (`BSTS_TCK_CYCLES / 2 - 1) @(posedge clk);
        o = tdo_oe ? tdo_pin : 1'bx;
        tck_pin <= 1'b1;
        repeat (`BSTS_TCK_CYCLES / 2) @(posedge clk);
        tck_pin <= 1'b0;
    endtask : step
    task automatic pins(input logic tms_drv, input logic tdi_drv, input logic trst_n);
        @(posedge clk);
        tms_driven <= tms_drv;
        tdi_driven <= tdi_drv;
        trst_n_pin <= trst_n;
    endtask : pins
endmodule : bsts_tester

/* tb/tb_boundary_scan_test_port.sv */
`timescale 1ns/1ps
`include "bsts_map.svh"
module tb_boundary_scan_test_port;
    import bsts_pkg::*;
    localparam logic [31:0] ID = 32'h5A3C_96E1; // arbitrary value, lsb one
    localparam logic [165:0] ACK = 166'h1 << `BSTS_DTA_CELL;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic tck_pin, tms_pin, tms_driven, tdi_pin, tdi_driven, trst_n_pin, trst_n_driven;
    logic [165:0] bnd_pins_in = '0;
    logic [165:0] bnd_cells_out, pat, got;
    logic tdo_pin, tdo_oe, extest_active, transfer_ack_pin_out, transfer_ack_pin_oe;
    bsts_state_e tap_state;
    int num_errors = 0;
    int tests_run = 0;

    always #2.5 clk = ~clk;

    bsts_tap #(.ID_VALUE(ID)) i_bsts_tap (.clk(clk), .reset(reset), .tck_pin(tck_pin),
        .tms_pin(tms_pin), .tms_driven(tms_driven), .tdi_pin(tdi_pin), .tdi_driven(tdi_driven),
        .trst_n_pin(trst_n_pin), .trst_n_driven(trst_n_driven), .bnd_pins_in(bnd_pins_in),
        .tdo_pin(tdo_pin), .tdo_oe(tdo_oe), .extest_active(extest_active),
        .bnd_cells_out(bnd_cells_out), .transfer_ack_pin_out(transfer_ack_pin_out),
        .transfer_ack_pin_oe(transfer_ack_pin_oe), .tap_state(tap_state));
    bsts_tester i_bsts_tester (.clk(clk), .tdo_pin(tdo_pin), .tdo_oe(tdo_oe), .tck_pin(tck_pin),
        .tms_pin(tms_pin), .tms_driven(tms_driven), .tdi_pin(tdi_pin), .tdi_driven(tdi_driven),
        .trst_n_pin(trst_n_pin), .trst_n_driven(trst_n_driven));

    task automatic check(input logic [165:0] g, input logic [165:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : check
    task automatic go(input logic m, input logic d);
        logic b;
        i_bsts_tester.step(m, d, b);
    endtask : go
    // from run-test-idle back to run-test-idle, tdo bits gathered lsb first
    task automatic scan(input logic ir, input int n, input logic [165:0] din);
        logic b;
        got = '0;
        go(1'b1, 1'b1);
        if (ir) go(1'b1, 1'b1);
        go(1'b0, 1'b1);
        go(1'b0, 1'b1);
        for (int k = 0; k < n; k++) begin
            i_bsts_tester.step(k == n - 1, din[k], b);
            got[k] = b;
        end
        go(1'b1, 1'b1);
        go(1'b0, 1'b1);
    endtask : scan
    task automatic t_bypass;
        go(1'b0, 1'b1);
        check(166'(tap_state), 166'(BSTS_RTI));
        scan(1'b0, 4, 166'h5);
        check(got, 166'hA);
        for (int op = 3; op < 7; op++) begin
            scan(1'b1, 3, 166'(op));
            scan(1'b0, 4, 166'h5);
            check(got, 166'hA);
        end
    endtask : t_bypass
    task automatic t_idcode;
        scan(1'b1, 3, 166'(`BSTS_OP_IDCODE));
        check(got, 166'(`BSTS_IR_CAPTURE));
        scan(1'b0, 32, 166'h0);
        check(got, 166'(ID));
    endtask : t_idcode
    task automatic t_boundary;
        pat = {{10{16'hA5C3}}, 6'h19};
        bnd_pins_in <= pat;
        scan(1'b1, 3, 166'(`BSTS_OP_SAMPLE));
        check(166'(extest_active), 166'h0);
        scan(1'b1, 3, 166'(`BSTS_OP_EXTEST));
        check(166'(extest_active), 166'h1);
        scan(1'b0, 166, ~pat | ACK);
        check(got, pat);
        check(bnd_cells_out, ~pat | ACK);
        check(166'(transfer_ack_pin_oe), 166'h1);
        scan(1'b0, 166, ~pat & ~ACK);
        check(166'(transfer_ack_pin_oe), 166'h0);
    endtask : t_boundary
    task automatic t_trst;
        i_bsts_tester.pins(1'b1, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        check(166'(tap_state), 166'(BSTS_TLR));
        check(bnd_cells_out, 166'h0);
        check(166'(extest_active), 166'h0);
        i_bsts_tester.pins(1'b1, 1'b1, 1'b1);
        go(1'b0, 1'b1);
        scan(1'b0, 4, 166'h5);
        check(got, 166'hA);
    endtask : t_trst
    // tms left floating but shown low: only the pull-up reaches reset
    task automatic t_float;
        i_bsts_tester.pins(1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 5; k++) go(1'b0, 1'b0);
        check(166'(tap_state), 166'(BSTS_TLR));
        // tdi left floating but shown low: bypass must pass ones
        i_bsts_tester.pins(1'b1, 1'b0, 1'b1);
        go(1'b0, 1'b0);
        scan(1'b0, 4, 166'h0);
        check(got, 166'hE);
        i_bsts_tester.pins(1'b1, 1'b1, 1'b1);
    endtask : t_float
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        i_bsts_tester.pins(1'b1, 1'b1, 1'b1);
        repeat (8) @(posedge clk);
        check(166'(tap_state), 166'(BSTS_TLR));
        t_bypass;
        t_idcode;
        t_boundary;
        t_trst;
        t_float;
        wrap_up;
    end
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        wrap_up;
    end
endmodule : tb_boundary_scan_test_port

bind bsts_tap bsts_tap_props i_bsts_tap_props (.clk(clk), .reset(reset), .tck_pin(tck_pin),
    .tms_pin(tms_pin), .tms_driven(tms_driven), .tdi_pin(tdi_pin), .tdi_driven(tdi_driven),
    .trst_n_pin(trst_n_pin), .trst_n_driven(trst_n_driven), .bnd_pins_in(bnd_pins_in),
    .tdo_pin(tdo_pin), .tdo_oe(tdo_oe), .extest_active(extest_active),
    .bnd_cells_out(bnd_cells_out), .transfer_ack_pin_out(transfer_ack_pin_out),
    .transfer_ack_pin_oe(transfer_ack_pin_oe), .tap_state(tap_state));
